// ==== rtl/lkd_pkg.sv ====
// constants and types for the link delay calibration register bank
package lkd_pkg;
    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int         ADDR_W   = 8;
    localparam int         DATA_W   = 32;
    localparam logic [7:0] OFS_RTD  = 8'h58;
    localparam logic [7:0] OFS_SLIP = 8'h5C;
    localparam logic [7:0] OFS_CALC = 8'h60;
    localparam logic [7:0] OFS_CALT = 8'h64;

    // ************************************************************
    // field widths and positions
    // ************************************************************
    localparam int RTD_W          = 20;
    localparam int SLIP_W         = 5;
    localparam int STEP_W         = 9;
    localparam int CYC_W          = 8;
    localparam int CUR_W          = 10;
    localparam int RX_SLIP_LSB    = 16;
    localparam int TX_SLIP_EN_BIT = 5;
    localparam int TX_SLIP_LSB    = 0;
    localparam int CAL_RST_BIT    = 16;
    localparam int CAL_CHK_BIT    = 8;
    localparam int CAL_EN_BIT     = 0;
    localparam int STEP_LSB       = 16;
    localparam int CYC_LSB        = 0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [RTD_W-1:0]  RTD_RST  = 20'h00000;
    localparam logic [SLIP_W-1:0] SLIP_RST = 5'h00;
    localparam logic [DATA_W-1:0] RD_ZERO  = 32'h00000000;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic rst;
        logic chk;
        logic en;
    } lkd_cal_ctrl_t;

    typedef struct packed {
        logic [STEP_W-1:0] step;
        logic [CYC_W-1:0]  cycle;
    } lkd_cal_target_t;

    localparam lkd_cal_ctrl_t   CAL_CTRL_RST = 3'h0;
    localparam lkd_cal_target_t CAL_TGT_RST  = 17'h00000;

    typedef enum logic {BUS_IDLE, BUS_ACK} lkd_bus_state_t;
    typedef enum logic {MEAS_IDLE, MEAS_COUNT} lkd_meas_state_t;
endpackage

// ==== rtl/lkd_pulse_delay.sv ====
// delays a trigger pulse by a programmable number of cycles
`timescale 1ns/1ps
`default_nettype none
module lkd_pulse_delay #(
    parameter int W = 20
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // trigger and delay
    input  wire logic         trig,
    input  wire logic [W-1:0] delay,
    // delayed pulse
    output var  logic         pulse_ff
);
    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ************************************************************
    // countdown
    // ************************************************************
    localparam logic [W-1:0] ONE  = W'(1);
    localparam logic [W-1:0] ZERO = W'(0);

    logic [W-1:0] cnt_ff;
    logic         busy_ff;
    wire          zero_dly = (delay == ZERO);
    wire          expire   = busy_ff && (cnt_ff == ONE);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff   <= ZERO;
            busy_ff  <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= (trig && zero_dly) || expire; // see RQ2
            if (trig && !zero_dly) begin
                cnt_ff  <= delay;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                cnt_ff  <= cnt_ff - ONE;
                busy_ff <= !expire;
            end
        end
    end

    zero_pulse_a: assert property ( // see RQ2
        trig && zero_dly |=> pulse_ff)
        else $error("zero delay did not pulse next cycle");
    two_pulse_a: assert property ( // see RQ2
        trig && delay == W'(2) ##1 !trig[*2] |-> !pulse_ff ##1 pulse_ff)
        else $error("delay of two misplaced");
endmodule
`default_nettype wire

// ==== rtl/lkd_regs.sv ====
// link delay calibration register bank with avalon-mm slave
//
// Functional notes
// RQ1 - round trip delay, 20 bits read only, in output clock periods
// RQ2 - measured delay shifts aux receive pulse against aux transmit pulse
// RQ3 - round trip field refreshed once per radio frame
// RQ4 - 5-bit read-only receive slip count, may change during xcvr reset
// RQ5 - receive slip updates on comma move while alignment active
// RQ6 - written transmit slip applied only while manual enable set
// RQ7 - transmit link gets slip bits held in 5-bit field
// RQ8 - software keeps transmit slip at most 9 or 19 by line rate
// RQ9 - calibration reset holds calibration logic and external unit in reset
// RQ10 - calibration reset keeps control bits, but overrides periodic check
// RQ11 - periodic check compares step plus cycle against current delay
// RQ12 - mismatch in consistency check starts a recalibration
// RQ13 - without periodic check, check only when enable is set
// RQ14 - calibration runs while enable is one, stops when zero
// RQ15 - target register exists only in slave variants with calibration
// RQ16 - 9-bit field gives fractional cycles in step units
// RQ17 - 8-bit field gives whole output clock cycles
// RQ18 - reserved bits read zero, writes to them ignored
`timescale 1ns/1ps
`default_nettype none
module lkd_regs #(
    parameter bit HAS_TARGET = 1'b1
) (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             sys_rst,
    // avalon-mm slave
    input  wire logic [lkd_pkg::ADDR_W-1:0]       avs_address,
    input  wire logic                             avs_read,
    input  wire logic                             avs_write,
    input  wire logic [lkd_pkg::DATA_W-1:0]       avs_writedata,
    output var  logic [lkd_pkg::DATA_W-1:0]       avs_readdata,
    output var  logic                             avs_waitrequest,
    // round trip measurement
    input  wire logic                             tx_sync_pulse,
    input  wire logic                             rx_sync_pulse,
    input  wire logic                             radio_frame_pulse,
    input  wire logic                             aux_transmit_frame_pulse,
    output var  logic                             aux_receive_frame_pulse,
    // word aligner and transmit slip
    input  wire logic [lkd_pkg::SLIP_W-1:0]       rx_slip_value,
    input  wire logic                             comma_moved,
    input  wire logic                             word_align_active,
    input  wire logic                             xcvr_resetting,
    output var  logic [lkd_pkg::SLIP_W-1:0]       tx_slip_value,
    // single-trip calibration
    input  wire logic                             hyperframe_pulse,
    input  wire logic [lkd_pkg::CUR_W-1:0]        cal_current_delay,
    output var  logic                             cal_logic_reset,
    output var  logic                             external_phase_unit_reset,
    output var  logic                             cal_active,
    output var  logic                             recal_start,
    output var  lkd_pkg::lkd_cal_target_t         cal_target
);
    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ************************************************************
    // declarations
    // ************************************************************
    lkd_pkg::lkd_bus_state_t    bus_state_ff;
    lkd_pkg::lkd_meas_state_t   meas_state_ff;
    lkd_pkg::lkd_cal_ctrl_t     cal_ctrl_ff;
    lkd_pkg::lkd_cal_target_t   cal_tgt_ff;
    logic [lkd_pkg::RTD_W-1:0]  count_ff;
    logic [lkd_pkg::RTD_W-1:0]  captured_ff;
    logic [lkd_pkg::RTD_W-1:0]  rtd_ff;
    logic [lkd_pkg::SLIP_W-1:0] rx_slip_ff;
    logic [lkd_pkg::SLIP_W-1:0] tx_slip_in_ff;
    logic                       tx_slip_en_ff;
    logic                       aux_tx_prev_ff;
    logic                       cal_en_prev_ff;

    localparam logic [lkd_pkg::RTD_W-1:0] CNT_ONE = 20'h00001;
    localparam logic [lkd_pkg::RTD_W-1:0] CNT_MAX = 20'hFFFFF;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(input logic [lkd_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    wire req      = avs_read || avs_write;
    wire sel_rtd  = hit(avs_address, lkd_pkg::OFS_RTD);
    wire sel_slip = hit(avs_address, lkd_pkg::OFS_SLIP);
    wire sel_calc = hit(avs_address, lkd_pkg::OFS_CALC);
    wire sel_calt = hit(avs_address, lkd_pkg::OFS_CALT) && HAS_TARGET;
    wire wr_take  = (bus_state_ff == lkd_pkg::BUS_ACK) && avs_write;

    // ************************************************************
    // read data mux, reserved bits zero
    // ************************************************************
    logic [lkd_pkg::DATA_W-1:0] rd_rtd;
    logic [lkd_pkg::DATA_W-1:0] rd_slip;
    logic [lkd_pkg::DATA_W-1:0] rd_calc;
    logic [lkd_pkg::DATA_W-1:0] rd_calt;
    logic [lkd_pkg::DATA_W-1:0] rd_mux;

    always_comb begin
        rd_rtd  = lkd_pkg::RD_ZERO;
        rd_slip = lkd_pkg::RD_ZERO;
        rd_calc = lkd_pkg::RD_ZERO;
        rd_calt = lkd_pkg::RD_ZERO;
        rd_rtd[lkd_pkg::RTD_W-1:0] = rtd_ff; // see RQ1
        rd_slip[lkd_pkg::RX_SLIP_LSB +: lkd_pkg::SLIP_W] =
            rx_slip_ff; // see RQ4
        rd_slip[lkd_pkg::TX_SLIP_EN_BIT] = tx_slip_en_ff;
        rd_slip[lkd_pkg::TX_SLIP_LSB +: lkd_pkg::SLIP_W] = tx_slip_in_ff;
        rd_calc[lkd_pkg::CAL_RST_BIT] = cal_ctrl_ff.rst;
        rd_calc[lkd_pkg::CAL_CHK_BIT] = cal_ctrl_ff.chk;
        rd_calc[lkd_pkg::CAL_EN_BIT]  = cal_ctrl_ff.en;
        rd_calt[lkd_pkg::STEP_LSB +: lkd_pkg::STEP_W] = cal_tgt_ff.step;
        rd_calt[lkd_pkg::CYC_LSB +: lkd_pkg::CYC_W]   = cal_tgt_ff.cycle;
    end

    assign rd_mux = sel_rtd  ? rd_rtd  : // see RQ18
                    sel_slip ? rd_slip :
                    sel_calc ? rd_calc :
                    sel_calt ? rd_calt : lkd_pkg::RD_ZERO;
    wire [lkd_pkg::DATA_W-1:0] rd_word = avs_read ? rd_mux : lkd_pkg::RD_ZERO;

    // ************************************************************
    // bus handshake
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_state_ff    <= lkd_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= lkd_pkg::RD_ZERO;
        end else begin
            case (bus_state_ff)
                lkd_pkg::BUS_IDLE: begin
                    if (req) begin
                        bus_state_ff    <= lkd_pkg::BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= rd_word;
                    end
                end
                lkd_pkg::BUS_ACK: begin
                    bus_state_ff    <= lkd_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state_ff    <= lkd_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // writable registers
    // ************************************************************
    wire [lkd_pkg::DATA_W-1:0] wd = avs_writedata;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_slip_in_ff <= lkd_pkg::SLIP_RST;
            tx_slip_en_ff <= 1'b0;
            cal_ctrl_ff   <= lkd_pkg::CAL_CTRL_RST;
            cal_tgt_ff    <= lkd_pkg::CAL_TGT_RST;
        end else if (wr_take) begin
            if (sel_slip) begin
                tx_slip_in_ff <= wd[lkd_pkg::TX_SLIP_LSB +: lkd_pkg::SLIP_W];
                tx_slip_en_ff <= wd[lkd_pkg::TX_SLIP_EN_BIT];
            end
            if (sel_calc) begin
                cal_ctrl_ff.rst <= wd[lkd_pkg::CAL_RST_BIT];
                cal_ctrl_ff.chk <= wd[lkd_pkg::CAL_CHK_BIT];
                cal_ctrl_ff.en  <= wd[lkd_pkg::CAL_EN_BIT];
            end
            if (sel_calt) begin // see RQ15
                cal_tgt_ff.step  <= // see RQ16
                    wd[lkd_pkg::STEP_LSB +: lkd_pkg::STEP_W];
                cal_tgt_ff.cycle <= // see RQ17
                    wd[lkd_pkg::CYC_LSB +: lkd_pkg::CYC_W];
            end
        end
    end

    // ************************************************************
    // round trip measurement
    // ************************************************************
    wire [lkd_pkg::RTD_W-1:0] count_inc =
        (count_ff == CNT_MAX) ? count_ff : count_ff + CNT_ONE;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meas_state_ff <= lkd_pkg::MEAS_IDLE;
            count_ff      <= lkd_pkg::RTD_RST;
            captured_ff   <= lkd_pkg::RTD_RST;
            rtd_ff        <= lkd_pkg::RTD_RST;
        end else begin
            case (meas_state_ff)
                lkd_pkg::MEAS_IDLE: begin
                    if (tx_sync_pulse) begin
                        count_ff      <= CNT_ONE;
                        meas_state_ff <= lkd_pkg::MEAS_COUNT;
                    end
                end
                lkd_pkg::MEAS_COUNT: begin
                    count_ff <= count_inc;
                    if (rx_sync_pulse) begin
                        captured_ff   <= count_ff; // see RQ1
                        meas_state_ff <= lkd_pkg::MEAS_IDLE;
                    end
                end
                default: meas_state_ff <= lkd_pkg::MEAS_IDLE;
            endcase
            if (radio_frame_pulse) begin
                rtd_ff <= captured_ff; // see RQ3
            end
        end
    end

    // ************************************************************
    // aux receive pulse placement
    // ************************************************************
    wire aux_tx_rise = aux_transmit_frame_pulse && !aux_tx_prev_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aux_tx_prev_ff <= 1'b0;
        end else begin
            aux_tx_prev_ff <= aux_transmit_frame_pulse;
        end
    end

    lkd_pulse_delay #(
        .W        (lkd_pkg::RTD_W)
    ) u_aux_delay (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .trig     (aux_tx_rise), // see RQ2
        .delay    (rtd_ff),
        .pulse_ff (aux_receive_frame_pulse)
    );

    // ************************************************************
    // bitslip
    // ************************************************************
    wire rx_slip_take = (comma_moved && word_align_active) || xcvr_resetting;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_slip_ff    <= lkd_pkg::SLIP_RST;
            tx_slip_value <= lkd_pkg::SLIP_RST;
        end else begin
            if (rx_slip_take) begin
                rx_slip_ff <= rx_slip_value; // see RQ4, RQ5
            end
            if (tx_slip_en_ff) begin
                tx_slip_value <= tx_slip_in_ff; // see RQ6, RQ7
            end
        end
    end

    // ************************************************************
    // calibration control and consistency check
    // ************************************************************
    wire [lkd_pkg::CUR_W-1:0] tgt_sum =
        lkd_pkg::CUR_W'(cal_tgt_ff.step) + lkd_pkg::CUR_W'(cal_tgt_ff.cycle);
    wire cal_run     = cal_ctrl_ff.en && !cal_ctrl_ff.rst; // see RQ10
    wire cal_en_rise = cal_ctrl_ff.en && !cal_en_prev_ff;
    wire periodic    = cal_ctrl_ff.chk && hyperframe_pulse; // see RQ11
    wire oneshot     = !cal_ctrl_ff.chk && cal_en_rise; // see RQ13
    wire check_now   = cal_run && (periodic || oneshot); // see RQ10
    wire mismatch    = (tgt_sum != cal_current_delay);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cal_en_prev_ff            <= 1'b0;
            cal_logic_reset           <= 1'b0;
            external_phase_unit_reset <= 1'b0;
            cal_active                <= 1'b0;
            recal_start               <= 1'b0;
            cal_target                <= lkd_pkg::CAL_TGT_RST;
        end else begin
            cal_en_prev_ff            <= cal_run;
            cal_logic_reset           <= cal_ctrl_ff.rst; // see RQ9
            external_phase_unit_reset <= cal_ctrl_ff.rst; // see RQ9
            cal_active                <= cal_run; // see RQ14
            recal_start               <= check_now && mismatch; // see RQ12
            cal_target                <= cal_tgt_ff;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    bus_answer_a: assert property ( // see RQ18
        bus_state_ff == lkd_pkg::BUS_IDLE && req |=>
            !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    rsvd_zero_a: assert property ( // see RQ18
        !avs_waitrequest |-> avs_readdata[31:25] == 7'h00)
        else $error("reserved read bits not zero");
    rtd_frame_a: assert property ( // see RQ3
        !radio_frame_pulse |=> $stable(rtd_ff))
        else $error("round trip field changed off frame");
    rtd_load_a: assert property ( // see RQ1
        radio_frame_pulse |=> rtd_ff == $past(captured_ff))
        else $error("round trip field not refreshed");
    rx_slip_a: assert property ( // see RQ5
        rx_slip_take |=> rx_slip_ff == $past(rx_slip_value))
        else $error("receive slip not captured");
    tx_slip_hold_a: assert property ( // see RQ6
        !tx_slip_en_ff |=> $stable(tx_slip_value))
        else $error("transmit slip changed while disabled");
    cal_reset_a: assert property ( // see RQ9
        cal_ctrl_ff.rst |=> cal_logic_reset && external_phase_unit_reset &&
            !cal_active)
        else $error("calibration reset not applied");
    no_recal_a: assert property ( // see RQ10
        cal_ctrl_ff.rst |=> !recal_start)
        else $error("recalibration during calibration reset");
    recal_fire_a: assert property ( // see RQ12
        periodic && cal_run && mismatch |=> recal_start)
        else $error("mismatch did not start recalibration");
    cal_run_a: assert property ( // see RQ14
        !cal_ctrl_ff.en |=> !cal_active)
        else $error("calibration active while disabled");
endmodule
`default_nettype wire

// ==== sim/lkd_regs_tb.sv ====
// self-checking bench for the link delay calibration register bank
`timescale 1ns/1ps
`default_nettype none
module lkd_regs_tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic                          clk          = 1'b0;
    logic                          sys_rst      = 1'b1;
    logic [7:0]                    avs_address  = 8'h00;
    logic                          avs_read     = 1'b0;
    logic                          avs_write    = 1'b0;
    logic [31:0]                   avs_writedata = 32'h00000000;
    logic [31:0]                   avs_readdata;
    logic                          avs_waitrequest;
    logic                          tx_sync      = 1'b0;
    logic                          rx_sync      = 1'b0;
    logic                          radio_frame  = 1'b0;
    logic                          aux_tx       = 1'b0;
    logic                          aux_rx;
    logic [4:0]                    rx_slip      = 5'h00;
    logic                          comma_moved  = 1'b0;
    logic                          align_on     = 1'b0;
    logic                          xcvr_rst     = 1'b0;
    logic [4:0]                    tx_slip;
    logic                          hyperframe   = 1'b0;
    logic [9:0]                    cur_delay    = 10'h009;
    logic                          cal_rst_out;
    logic                          epu_rst_out;
    logic                          cal_active;
    logic                          recal_start;
    lkd_pkg::lkd_cal_target_t      cal_target;
    int                            num_errors   = 0;
    int                            n_tests      = 0;
    int                            recal_cnt    = 0;
    int                            cyc          = 0;
    int                            rise_cyc     = 0;
    int                            pulse_cyc    = 0;
    logic                          aux_prev     = 1'b0;

    always #2.5 clk = ~clk;

    lkd_regs dut_u (
        .clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_sync_pulse(tx_sync), .rx_sync_pulse(rx_sync),
        .radio_frame_pulse(radio_frame),
        .aux_transmit_frame_pulse(aux_tx),
        .aux_receive_frame_pulse(aux_rx),
        .rx_slip_value(rx_slip), .comma_moved(comma_moved),
        .word_align_active(align_on), .xcvr_resetting(xcvr_rst),
        .tx_slip_value(tx_slip), .hyperframe_pulse(hyperframe),
        .cal_current_delay(cur_delay), .cal_logic_reset(cal_rst_out),
        .external_phase_unit_reset(epu_rst_out),
        .cal_active(cal_active), .recal_start(recal_start),
        .cal_target(cal_target)
    );

    // ************************************************************
    // monitors
    // ************************************************************
    always @(posedge clk) begin
        cyc++;
        if (recal_start === 1'b1) recal_cnt++;
        if (aux_tx === 1'b1 && aux_prev === 1'b0) rise_cyc = cyc;
        if (aux_rx === 1'b1) pulse_cyc = cyc;
        aux_prev = aux_tx;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h00000000, v);
        chk(nm, v, exp);
    endtask

    task automatic hf();
        @(posedge clk) hyperframe <= 1'b1;
        @(posedge clk) hyperframe <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // watchdog
    // ************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd("rtd_rst", 8'h58, 32'h00000000);
        rd("slip_rst", 8'h5C, 32'h00000000);
        rd("calc_rst", 8'h60, 32'h00000000);
        rd("calt_rst", 8'h64, 32'h00000000);
        wr(8'h68, 32'hFFFFFFFF);
        rd("unmapped", 8'h68, 32'h00000000);
        // zero delay puts the receive pulse one cycle after the rise
        @(posedge clk) aux_tx <= 1'b1;
        repeat (3) @(posedge clk);
        chk("aux_zero", pulse_cyc - rise_cyc, 32'h00000001);
        aux_tx <= 1'b0;
        // round trip of five cycles, visible only after frame pulse
        @(posedge clk) tx_sync <= 1'b1;
        @(posedge clk) tx_sync <= 1'b0;
        repeat (4) @(posedge clk);
        rx_sync <= 1'b1;
        @(posedge clk) rx_sync <= 1'b0;
        rd("rtd_stale", 8'h58, 32'h00000000);
        @(posedge clk) radio_frame <= 1'b1;
        @(posedge clk) radio_frame <= 1'b0;
        rd("rtd_val", 8'h58, 32'h00000005);
        @(posedge clk) aux_tx <= 1'b1;
        repeat (12) @(posedge clk);
        chk("aux_shift", pulse_cyc - rise_cyc, 32'h00000006);
        aux_tx <= 1'b0;
        // round trip of two cycles, then a short receive pulse delay
        @(posedge clk) tx_sync <= 1'b1;
        @(posedge clk) tx_sync <= 1'b0;
        @(posedge clk) rx_sync <= 1'b1;
        @(posedge clk) rx_sync <= 1'b0;
        radio_frame <= 1'b1;
        @(posedge clk) radio_frame <= 1'b0;
        aux_tx <= 1'b1;
        repeat (6) @(posedge clk);
        chk("aux_two", pulse_cyc - rise_cyc, 32'h00000003);
        aux_tx <= 1'b0;
        rd("rtd_two", 8'h58, 32'h00000002);
        // transmit slip only with enable
        wr(8'h5C, 32'h00000007);
        repeat (2) @(posedge clk);
        chk("tx_slip_off", {27'h0, tx_slip}, 32'h00000000);
        wr(8'h5C, 32'hFFFFFFE7);
        repeat (2) @(posedge clk);
        chk("tx_slip_on", {27'h0, tx_slip}, 32'h00000007);
        // receive slip on comma move only while aligning
        rx_slip <= 5'h13;
        comma_moved <= 1'b1;
        @(posedge clk) comma_moved <= 1'b0;
        rd("rx_slip_idle", 8'h5C, 32'h00000027);
        align_on <= 1'b1;
        comma_moved <= 1'b1;
        @(posedge clk) comma_moved <= 1'b0;
        align_on <= 1'b0;
        rd("rx_slip_move", 8'h5C, 32'h00130027);
        rx_slip <= 5'h0B;
        xcvr_rst <= 1'b1;
        repeat (2) @(posedge clk);
        xcvr_rst <= 1'b0;
        rd("rx_slip_xrst", 8'h5C, 32'h000B0027);
        // target fields
        wr(8'h64, 32'hFFFFFFFF);
        rd("calt_mask", 8'h64, 32'h01FF00FF);
        chk("tgt_full", {15'h0, cal_target}, 32'h0001FFFF);
        wr(8'h64, 32'h00030005);
        repeat (2) @(posedge clk);
        chk("tgt_val", {15'h0, cal_target}, 32'h00000305);
        // calibration reset keeps bits but overrides check
        wr(8'h60, 32'hFFFFFFFF);
        rd("calc_mask", 8'h60, 32'h00010101);
        chk("cal_rst", {30'h0, cal_rst_out, epu_rst_out}, 32'h3);
        chk("cal_off_rst", {31'h0, cal_active}, 32'h0);
        hf();
        chk("no_chk_rst", recal_cnt, 32'h0);
        wr(8'h60, 32'h00000001);
        repeat (4) @(posedge clk);
        chk("recal_en", recal_cnt, 32'h1);
        chk("cal_run", {31'h0, cal_active}, 32'h1);
        chk("rst_free", {30'h0, cal_rst_out, epu_rst_out}, 32'h0);
        hf();
        chk("no_chk_hf", recal_cnt, 32'h1);
        wr(8'h60, 32'h00000000);
        wr(8'h60, 32'h00000001);
        repeat (4) @(posedge clk);
        chk("recal_reen", recal_cnt, 32'h2);
        wr(8'h60, 32'h00000101);
        hf();
        chk("recal_hf", recal_cnt, 32'h3);
        cur_delay <= 10'h008;
        hf();
        chk("match_hf", recal_cnt, 32'h3);
        cur_delay <= 10'h009;
        wr(8'h60, 32'h00000100);
        hf();
        chk("cal_stop", {31'h0, cal_active}, 32'h0);
        chk("no_chk_off", recal_cnt, 32'h3);
        results();
    end
endmodule
`default_nettype wire
